// file: bridge_cfg_defines.svh
// offsets, field positions, reset values and timing counts of the bridge config window
`ifndef BRIDGE_CFG_DEFINES_SVH
`define BRIDGE_CFG_DEFINES_SVH
`define OFS_IO_FLOOR_HI 8'h30
`define OFS_IO_CEIL_HI 8'h32
`define OFS_CAP_PTR 8'h34
`define OFS_IRQ_LINE 8'h3C
`define OFS_IRQ_PIN 8'h3D
`define OFS_BRIDGE_CTL 8'h3E
`define RST_IO_FLOOR_HI 16'h0000
`define RST_IO_CEIL_HI 16'h0000
`define VAL_CAP_PTR 8'h50
`define RST_IRQ_LINE 8'hFF
`define VAL_IRQ_PIN 8'h00
`define BIT_MSG_ENABLE 11
`define BIT_DISCARD_FLAG 10
`define BIT_INTERVAL_SEL 9
`define LOW_FLOOR_FILL 20'h00000
`define LOW_CEIL_FILL 20'hFFFFF
`define DISCARD_LONG_CYCLES 16'h8000
`define DISCARD_SHORT_CYCLES 16'h0400
`endif

// file: bridge_cfg_pkg.sv
// types shared by the bridge config window
package bridge_cfg_pkg;
   typedef enum logic [2:0] {
      DT_IDLE = 3'b001,
      DT_COUNT = 3'b010,
      DT_EXPIRE = 3'b100
   } discard_state_t;
endpackage

// file: bridge_io_window_and_control_cfg.sv
// config registers for the bridge i/o window, irq bytes and discard-timer control
// What this block does
// - writable i/o window floor upper, resets zero
// - writable i/o window ceiling upper, resets zero
// - capabilities pointer reads fixed 50h
// - interrupt line scratchpad, resets FFh
// - interrupt pin reads zero, ignores writes
// - secondary interrupts pass through to primary
// - control bits 15:12 read zero
// - message enable sends error on discard expiry in conventional pci mode
// - fatal severity only with error reporting
// - unmasked error reporting also sends message
// - read-to-clear flag set on discard expiry
// - discard timer counts 2^15 or 2^10 cycles
`timescale 1ns/1ns
`include "bridge_cfg_defines.svh"

module bridge_io_window_and_control_cfg
   import bridge_cfg_pkg::*;
   #(
   parameter bit AER_PRESENT = 1'b1 // error reporting capability built in
   ) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic cfg_wr, // config write strobe, one cycle
   input wire logic cfg_rd, // config read strobe, one cycle
   input wire logic [7:0] cfg_addr, // dword-aligned config offset
   input wire logic [3:0] cfg_be, // byte enables of the dword
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata, // registered read data
   input wire logic conventional_pci_mode, // conventional pci mode active
   input wire logic aer_fatal_select, // severity from error reporting block
   input wire logic aer_discard_mask, // discard mask in uncorrectable mask
   input wire logic completion_at_head, // pulse: delayed completion at head
   input wire logic master_repeated, // pulse: secondary master repeated request
   output logic discard_drop, // pulse: delayed transaction dropped
   output logic err_nonfatal_msg, // pulse: nonfatal message request
   output logic err_fatal_msg, // pulse: fatal message request
   input wire logic io_req_valid, // i/o request from primary side
   input wire logic [31:0] io_req_addr,
   output logic io_forward, // request falls inside the window
   input wire logic [3:0] sec_irq, // secondary interrupt levels
   output logic [3:0] pri_irq, // forwarded interrupt levels
   output logic prst_req, // secondary bus reset bit
   output logic fbb_enable // fast back-to-back enable bit
);

   logic [15:0] floor_hi_q, floor_hi_d; // window floor upper
   logic [15:0] ceil_hi_q, ceil_hi_d; // window ceiling upper
   logic [7:0] irq_line_q, irq_line_d; // scratchpad only
   logic msg_en_q, msg_en_d; // discard expiry message enable
   logic flag_q, flag_d; // discard expiry flag
   logic sel_q, sel_d; // discard interval select
   logic fbb_q, fbb_d;
   logic srst_q, srst_d;
   logic [31:0] rdata_q, rdata_d;
   logic [3:0] irq_s1_q, irq_s2_q; // two-stage sync of the async irq levels
   discard_state_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d; // discard timer
   logic drop_q, drop_d, nf_q, nf_d, fa_q, fa_d;
   logic [15:0] bctl; // assembled control word

   // true when the strobe addresses the given dword
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction

   // merge one byte lane when its enable is set
   function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                       input logic en);
      lane = en ? nw : old;
   endfunction

   always_comb begin
      bctl = 16'h0000; // 15:12 and unheld bits read zero
      bctl[`BIT_MSG_ENABLE] = msg_en_q;
      bctl[`BIT_DISCARD_FLAG] = flag_q;
      bctl[`BIT_INTERVAL_SEL] = sel_q;
      bctl[7] = fbb_q;
      bctl[6] = srst_q;
   end

   // register writes and reads
   always_comb begin
      floor_hi_d = floor_hi_q;
      ceil_hi_d = ceil_hi_q;
      irq_line_d = irq_line_q;
      msg_en_d = msg_en_q;
      sel_d = sel_q;
      fbb_d = fbb_q;
      srst_d = srst_q;
      flag_d = flag_q;
      rdata_d = rdata_q;
      if (cfg_wr) begin
         if (hit(cfg_addr, `OFS_IO_FLOOR_HI)) begin
            floor_hi_d[7:0] = lane(floor_hi_q[7:0], cfg_wdata[7:0], cfg_be[0]);
            floor_hi_d[15:8] = lane(floor_hi_q[15:8], cfg_wdata[15:8], cfg_be[1]);
            ceil_hi_d[7:0] = lane(ceil_hi_q[7:0], cfg_wdata[23:16], cfg_be[2]);
            ceil_hi_d[15:8] = lane(ceil_hi_q[15:8], cfg_wdata[31:24], cfg_be[3]);
         end else if (hit(cfg_addr, `OFS_IRQ_LINE)) begin
            // pin byte and top nibble have no storage, writes vanish
            irq_line_d = lane(irq_line_q, cfg_wdata[7:0], cfg_be[0]);
            if (cfg_be[2]) begin
               fbb_d = cfg_wdata[23];
               srst_d = cfg_wdata[22];
            end
            if (cfg_be[3]) begin
               msg_en_d = cfg_wdata[27];
               sel_d = cfg_wdata[25];
            end
         end
      end
      if (cfg_rd) begin
         if (hit(cfg_addr, `OFS_IO_FLOOR_HI)) begin
            rdata_d = {ceil_hi_q, floor_hi_q};
         end else if (hit(cfg_addr, `OFS_CAP_PTR)) begin
            rdata_d = {24'h000000, `VAL_CAP_PTR};
         end else if (hit(cfg_addr, `OFS_IRQ_LINE)) begin
            rdata_d = {bctl, `VAL_IRQ_PIN, irq_line_q};
            if (cfg_be[3]) begin
               flag_d = 1'b0; // read clears flag
            end
         end else begin
            rdata_d = 32'h00000000; // outside this window
         end
      end
      if (drop_d) begin
         flag_d = 1'b1; // set beats the read clear
      end
   end

   // discard timer: idle, counting after completion reaches head, expiry
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      drop_d = 1'b0;
      case (st_q)
         DT_IDLE: begin
            if (completion_at_head) begin
               st_d = DT_COUNT;
               cnt_d = sel_q ? `DISCARD_SHORT_CYCLES - 16'h0001
                             : `DISCARD_LONG_CYCLES - 16'h0001;
            end
         end
         DT_COUNT: begin
            if (master_repeated) begin
               st_d = DT_IDLE; // served in time
            end else if (cnt_q == 16'h0000) begin
               st_d = DT_EXPIRE;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
         DT_EXPIRE: begin
            drop_d = 1'b1;
            st_d = DT_IDLE;
         end
         default: begin
            st_d = DT_IDLE;
         end
      endcase
   end

   // error message choice on a drop
   always_comb begin
      logic send;
      logic fatal;
      send = 1'b0;
      fatal = 1'b0;
      if (drop_d) begin
         send = (msg_en_q && conventional_pci_mode)
              || (AER_PRESENT && !aer_discard_mask);
         fatal = AER_PRESENT && aer_fatal_select;
      end
      nf_d = send && !fatal;
      fa_d = send && fatal;
   end

   // state registers; the first sync stage feeds only the second, which drives pri_irq
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         floor_hi_q <= `RST_IO_FLOOR_HI;
         ceil_hi_q <= `RST_IO_CEIL_HI;
         irq_line_q <= `RST_IRQ_LINE;
         msg_en_q <= 1'b0;
         flag_q <= 1'b0;
         sel_q <= 1'b0;
         fbb_q <= 1'b0;
         srst_q <= 1'b0;
         rdata_q <= 32'h00000000;
         st_q <= DT_IDLE;
         cnt_q <= 16'h0000;
         drop_q <= 1'b0;
         nf_q <= 1'b0;
         fa_q <= 1'b0;
         irq_s1_q <= 4'h0;
         irq_s2_q <= 4'h0;
      end else begin
         floor_hi_q <= floor_hi_d;
         ceil_hi_q <= ceil_hi_d;
         irq_line_q <= irq_line_d;
         msg_en_q <= msg_en_d;
         flag_q <= flag_d;
         sel_q <= sel_d;
         fbb_q <= fbb_d;
         srst_q <= srst_d;
         rdata_q <= rdata_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         drop_q <= drop_d;
         nf_q <= nf_d;
         fa_q <= fa_d;
         irq_s1_q <= sec_irq;
         irq_s2_q <= irq_s1_q;
      end
   end

   // window compare is combinational so forwarding adds no latency
   assign io_forward = io_req_valid
      && (io_req_addr >= {floor_hi_q[11:0], `LOW_FLOOR_FILL})
      && (io_req_addr <= {ceil_hi_q[11:0], `LOW_CEIL_FILL});
   assign cfg_rdata = rdata_q;
   assign discard_drop = drop_q;
   assign err_nonfatal_msg = nf_q;
   assign err_fatal_msg = fa_q;
   assign pri_irq = irq_s2_q;
   assign prst_req = srst_q;
   assign fbb_enable = fbb_q;

endmodule // bridge_io_window_and_control_cfg

// file: bridge_cfg_monitor.sv
// port checker for the bridge config window
`timescale 1ns/1ns
module bridge_cfg_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_rdata,
   input wire logic conventional_pci_mode,
   input wire logic aer_discard_mask,
   input wire logic discard_drop,
   input wire logic err_nonfatal_msg,
   input wire logic err_fatal_msg,
   input wire logic io_req_valid,
   input wire logic io_forward,
   input wire logic [3:0] sec_irq,
   input wire logic [3:0] pri_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // control dword read that clears the flag
   sequence s_ctl_rd;
      cfg_rd && cfg_addr[7:2] == 6'h0F && cfg_be[3];
   endsequence
   // two clearing reads with no drop around them
   sequence s_two_reads;
      !discard_drop ##1 (!discard_drop throughout (s_ctl_rd ##3 s_ctl_rd));
   endsequence
   a_cap_ptr_fixed: assert property (cfg_rd && cfg_addr[7:2] == 6'h0D |=> cfg_rdata[7:0] == 8'h50)
      else $error("cap pointer wrong");
   a_pin_rsvd_zero: assert property (s_ctl_rd |=> cfg_rdata[15:8] == 8'h00 && cfg_rdata[31:28] == 4'h0)
      else $error("pin or reserved bits set");
   a_flag_read_clear: assert property (s_two_reads |=> !cfg_rdata[26])
      else $error("flag not cleared");
   a_nonfatal_on_drop: assert property (err_nonfatal_msg |-> discard_drop)
      else $error("nonfatal without drop");
   a_fatal_one_kind: assert property (err_fatal_msg |-> discard_drop && !err_nonfatal_msg)
      else $error("fatal message wrong");
   a_masked_no_msg: assert property (discard_drop && aer_discard_mask && !conventional_pci_mode
      |-> !err_nonfatal_msg && !err_fatal_msg)
      else $error("message while off");
   a_drop_one_cycle: assert property (discard_drop |=> !discard_drop)
      else $error("drop too long");
   a_irq_pass_through: assert property ($stable(sec_irq)[*3] |-> pri_irq == sec_irq)
      else $error("irq not forwarded");
   a_fwd_needs_valid: assert property (io_forward |-> io_req_valid)
      else $error("forward without request");
endmodule // bridge_cfg_monitor

bind bridge_io_window_and_control_cfg bridge_cfg_monitor mon (.clk(clk), .nrst(nrst),
   .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
   .conventional_pci_mode(conventional_pci_mode), .aer_discard_mask(aer_discard_mask),
   .discard_drop(discard_drop), .err_nonfatal_msg(err_nonfatal_msg),
   .err_fatal_msg(err_fatal_msg), .io_req_valid(io_req_valid), .io_forward(io_forward),
   .sec_irq(sec_irq), .pri_irq(pri_irq));

// file: cfg_requester.sv
// upstream requester model issuing config reads and writes
`timescale 1ns/1ns
module cfg_requester (
   input wire logic clk,
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata
);
   // bus idle at time zero
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0;
   end
   // one-cycle write strobe, data inverted once released
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
      cfg_wdata = ~d;
   endtask
   // one-cycle read strobe, data taken once settled
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge clk);
      cfg_addr = a;
      cfg_be = 4'hF;
      cfg_rd = 1'b1;
      @(negedge clk);
      cfg_rd = 1'b0;
      @(negedge clk);
      d = cfg_rdata;
   endtask
endmodule // cfg_requester

// file: tb_bridge_io_window_and_control_cfg.sv
// self-checking bench for the bridge config window
`timescale 1ns/1ns
module tb_bridge_io_window_and_control_cfg;
   logic clk = 1'b0, nrst = 1'b0, cfg_wr, cfg_rd;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be, pri_irq, sec_irq = 4'h0;
   logic [31:0] cfg_wdata, cfg_rdata, rd_v, io_req_addr = 32'h0;
   logic conventional_pci_mode = 1'b0, aer_fatal_select = 1'b0, aer_discard_mask = 1'b1;
   logic completion_at_head = 1'b0, master_repeated = 1'b0, io_req_valid = 1'b0;
   logic discard_drop, err_nonfatal_msg, err_fatal_msg, io_forward, prst_req, fbb_enable;
   // {pci mode, enable, fatal, mask, expected nonfatal, expected fatal}
   logic [5:0] mode [4] = '{6'h36, 6'h3D, 6'h22, 6'h14};
   logic [31:0] win_a [4] = '{32'h000FFFFF, 32'h00100000, 32'h002FFFFF, 32'h00300000};
   int failures = 0, check_count = 0, n, k;
   initial forever #50 clk = ~clk;
   bridge_io_window_and_control_cfg DUT (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .conventional_pci_mode(conventional_pci_mode),
      .aer_fatal_select(aer_fatal_select), .aer_discard_mask(aer_discard_mask),
      .completion_at_head(completion_at_head), .master_repeated(master_repeated),
      .discard_drop(discard_drop), .err_nonfatal_msg(err_nonfatal_msg),
      .err_fatal_msg(err_fatal_msg), .io_req_valid(io_req_valid), .io_req_addr(io_req_addr),
      .io_forward(io_forward), .sec_irq(sec_irq), .pri_irq(pri_irq), .prst_req(prst_req),
      .fbb_enable(fbb_enable));
   cfg_requester host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
   // compare one value, count and report
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // counts and verdict, then stop
   task automatic complete_run();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // start the discard timer, wait a bounded time for a drop
   task automatic run_timer(input int rep, input int lim);
      completion_at_head = 1'b1;
      @(negedge clk);
      completion_at_head = 1'b0;
      repeat (rep) @(negedge clk);
      master_repeated = (rep > 0);
      k = 0;
      while (discard_drop !== 1'b1 && k < lim) begin
         @(negedge clk);
         master_repeated = 1'b0;
         k++;
      end
   endtask
   initial begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      host.rd(8'h30, rd_v);
      chk("window reset", 32'h0, rd_v);
      host.rd(8'h3C, rd_v);
      chk("line reset", 32'hFF, rd_v);
      host.wr(8'h30, 4'hF, 32'h00020001);
      host.wr(8'h34, 4'hF, 32'hFFFFFFFF);
      host.wr(8'h38, 4'hF, 32'hFFFFFFFF);
      host.wr(8'h3C, 4'hF, 32'hF2C0FF5A);
      host.rd(8'h30, rd_v);
      chk("window", 32'h00020001, rd_v);
      host.rd(8'h34, rd_v);
      chk("cap pointer", 32'h50, rd_v);
      host.rd(8'h38, rd_v);
      chk("unmapped", 32'h0, rd_v);
      host.rd(8'h3C, rd_v);
      chk("line pin ctl", 32'h02C0005A, rd_v);
      chk("ctl outputs", 32'h3, {30'h0, prst_req, fbb_enable});
      $display("register test done");
      io_req_valid = 1'b1;
      // floor 00100000h, ceiling 002FFFFFh: both ends inclusive
      for (n = 0; n < 4; n++) begin
         @(negedge clk);
         io_req_addr = win_a[n];
         #10;
         chk("io forward", {31'h0, n == 1 || n == 2}, {31'h0, io_forward});
      end
      $display("window test done");
      @(negedge clk);
      sec_irq = 4'hA;
      repeat (3) @(negedge clk);
      chk("irq forward", 32'hA, {28'h0, pri_irq});
      $display("irq test done");
      // short interval, enable set: a repeated request is not dropped
      host.wr(8'h3C, 4'hC, 32'h0AC00000);
      run_timer(100, 1100);
      chk("no drop", 32'h0, {31'h0, discard_drop});
      for (n = 0; n < 4; n++) begin
         {conventional_pci_mode, aer_fatal_select, aer_discard_mask} = {mode[n][5], mode[n][3:2]};
         host.wr(8'h3C, 4'hC, {4'h0, mode[n][4], 11'h2C0, 16'h0});
         run_timer(0, 1100);
         chk("drop seen", 32'h1, {31'h0, discard_drop});
         if (discard_drop !== 1'b1) complete_run();
         chk("interval", 32'h1, 32'(k > 1019 && k < 1031));
         chk("msg kind", {30'h0, mode[n][1:0]}, {30'h0, err_nonfatal_msg, err_fatal_msg});
         host.rd(8'h3C, rd_v);
         chk("flag set", 32'h1, {31'h0, rd_v[26]});
         host.rd(8'h3C, rd_v);
         chk("flag clear", 32'h0, {31'h0, rd_v[26]});
      end
      // select bit cleared: the default long interval, messages still off
      host.wr(8'h3C, 4'h8, 32'h00000000);
      run_timer(0, 33000);
      chk("drop long", 32'h1, {31'h0, discard_drop});
      if (discard_drop !== 1'b1) complete_run();
      chk("long interval", 32'h1, 32'(k > 32763 && k < 32775));
      chk("long msg", 32'h0, {30'h0, err_nonfatal_msg, err_fatal_msg});
      $display("timer test done");
      complete_run();
   end
endmodule // tb_bridge_io_window_and_control_cfg
